// [reset_source_sequencer_tb.sv]
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer_tb;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        start = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic [16:0] strap = 17'h0;
    logic        bs = 1'b0;
    logic [5:0]  req = 6'h0;
    logic        scan_valid = 1'b0;
    logic [1:0]  scan_cmd = 2'h0;
    logic        clamp_soft = 1'b0;
    wire logic        por, bs_pin, busy;
    wire logic [2:0]  sel_pin;
    wire logic [16:0] strap_pin;
    logic        h_out, h_oe, s_out, s_oe, pb, core, icf, icp, tmr, cmf, cmm, cv, cbs;
    logic [1:0]  corg;
    logic [2:0]  csel;
    logic [16:0] cstrap;
    logic [3:0]  last;
    logic [31:0] vec, cfg;
    int          bad_count = 0;
    int          comparisons = 0;

    always #2.5 mclk_in = ~mclk_in;
    assign vec = {17'h0, h_out, s_out, h_oe, s_oe, pb, core, icf, icp, tmr, cmf, cmm, last};
    assign cfg = {8'h0, cv, corg, csel, cbs, cstrap};

    rss_board_model #(.EXTRA(0)) rss_board_model_inst (
        .mclk_in(mclk_in), .start_in(start), .sel_in(sel), .strap_in(strap), .boot_stop_in(bs),
        .power_on_reset_out(por), .sel_out(sel_pin), .strap_out(strap_pin), .boot_stop_out(bs_pin),
        .busy_out(busy));

    rss_reset_source_sequencer rss_reset_source_sequencer_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .power_on_reset_in(por),
        .ext_hard_reset_in(req[0]), .wdog_hard_req_in(req[1]), .sw_hard_req_in(req[2]),
        .link_hard_req_in(req[3]), .ext_soft_reset_in(req[4]), .sw_soft_req_in(req[5]),
        .scan_cmd_valid_in(scan_valid), .scan_cmd_in(scan_cmd), .scan_clamp_soft_in(clamp_soft),
        .config_word_source_sel(sel_pin), .config_strap_pins(strap_pin), .boot_stop_strap(bs_pin),
        .hard_reset_line_out(h_out), .hard_reset_line_oe_out(h_oe), .soft_reset_line_out(s_out),
        .soft_reset_line_oe_out(s_oe), .periph_bus_rst_out(pb), .ext_core_rst_out(core),
        .icn_full_rst_out(icf), .icn_part_rst_out(icp), .timer_pmon_rst_out(tmr),
        .comms_full_rst_out(cmf), .comms_most_rst_out(cmm), .cfg_origin_out(corg),
        .cfg_src_sel_out(csel), .cfg_strap_out(cstrap), .cfg_boot_stop_out(cbs),
        .cfg_valid_out(cv), .last_source_out(last));

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // power-on sequence through the supervisor model, then the latched configuration
    task automatic por_seq(input logic [2:0] s, input logic [16:0] st, input logic b, input logic [1:0] org);
        int n;
        sel = s;
        strap = st;
        bs = b;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(8);
        chk(32'h1ff1, vec);
        n = 0;
        while (busy && n < 200) begin
            tick(1);
            n++;
        end
        tick(rss_pkg::STRETCH_CYCLES + 4);
        chk(32'h0001, vec);
        // straps were inverted by the board well before this point
        chk({8'h0, 1'b1, org, s, b & (org == 2'h0), st}, cfg);
    endtask

    // level source held, checked during, in the stretch and after
    task automatic src_seq(input int i, input logic [31:0] on, input logic [31:0] off);
        req[i] = 1'b1;
        tick(8);
        chk(on, vec);
        req[i] = 1'b0;
        tick(10);
        chk(on, vec);
        tick(rss_pkg::STRETCH_CYCLES);
        chk(off, vec);
    endtask

    task automatic scan_seq(input logic [1:0] c, input logic cs, input logic [31:0] on,
                            input logic [31:0] mask);
        scan_cmd = c;
        clamp_soft = cs;
        scan_valid = 1'b1;
        tick(5);
        chk(on, vec & mask);
        scan_valid = 1'b0;
        tick(rss_pkg::STRETCH_CYCLES + 10);
        chk(32'h0008, vec);
    endtask

    task automatic test_done;
        $display("errors=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk_in);
        #1;
        reset_in = 1'b0;
        tick(1);
        chk(32'h0, vec);
        chk(32'h00400000, cfg);
        por_seq(3'h1, 17'h0a5c3, 1'b1, 2'h1);
        por_seq(3'h0, 17'h15a3c, 1'b1, 2'h0);
        por_seq(3'h5, 17'h10001, 1'b0, 2'h2);
        for (int i = 0; i < 4; i++) begin
            src_seq(i, 32'h1ff2, 32'h0002);
        end
        chk({8'h0, 1'b1, 2'h2, 3'h5, 1'b0, 17'h10001}, cfg);
        for (int i = 4; i < 6; i++) begin
            src_seq(i, 32'h0e94, 32'h0004);
        end
        scan_seq(rss_pkg::JCMD_CLAMP, 1'b1, 32'h0e98, 32'hffffffff);
        scan_seq(rss_pkg::JCMD_CLAMP, 1'b0, 32'h0698, 32'hffffffff);
        scan_seq(rss_pkg::JCMD_EXTEST, 1'b0, 32'h0e98, 32'hffffffff);
        scan_seq(rss_pkg::JCMD_HIGHZ, 1'b0, 32'h0e98, 32'hffffffff);
        // stronger source arriving in the middle of a soft reset
        req[4] = 1'b1;
        tick(8);
        req[0] = 1'b1;
        tick(8);
        chk(32'h1ff2, vec);
        req = 6'h0;
        tick(4);
        // scan request inside the stretch must be absorbed
        scan_cmd = rss_pkg::JCMD_CLAMP;
        scan_valid = 1'b1;
        tick(3);
        scan_valid = 1'b0;
        tick(rss_pkg::STRETCH_CYCLES + 10);
        chk(32'h0002, vec);
        test_done();
    end

    initial begin
        repeat (5000) @(posedge mclk_in);
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire

// [rss_board_model.sv]
// board side: power-on supervisor and reset strap pins
`timescale 1ns/1ps
`default_nettype none
module rss_board_model #(
    parameter int unsigned EXTRA = 0
) (
    input  wire logic        mclk_in,
    input  wire logic        start_in,
    input  wire logic [2:0]  sel_in,
    input  wire logic [16:0] strap_in,
    input  wire logic        boot_stop_in,
    output logic             power_on_reset_out,
    output logic [2:0]       sel_out,
    output logic [16:0]      strap_out,
    output logic             boot_stop_out,
    output logic             busy_out
);
    int unsigned cnt;

    initial begin
        power_on_reset_out = 1'b0;
        sel_out            = 3'h7;
        strap_out          = 17'h1ffff;
        boot_stop_out      = 1'b0;
        busy_out           = 1'b0;
        cnt                = 0;
    end

    always @(posedge mclk_in) begin
        if (start_in && !busy_out) begin
            busy_out           <= 1'b1;
            cnt                <= 0;
            power_on_reset_out <= 1'b1;
            sel_out            <= sel_in;
            strap_out          <= strap_in;
            boot_stop_out      <= boot_stop_in;
        end else if (busy_out) begin
            cnt <= cnt + 1;
            if (cnt == rss_pkg::POR_MIN_CYCLES + EXTRA - 1) begin
                power_on_reset_out <= 1'b0;
            end
            // select and strap pins no longer held once reset is long over: show the inverse; boot-stop keeps its value
            if (cnt == rss_pkg::POR_MIN_CYCLES + EXTRA + 8) begin
                sel_out   <= ~sel_out;
                strap_out <= ~strap_out;
                busy_out  <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rss_cfg_latch.sv]
// configuration latch for strap and source-select pins
`timescale 1ns/1ps
`default_nettype none
module rss_cfg_latch (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        capture_in,
    input  wire logic        commit_in,
    input  wire logic [2:0]  src_sel_in,
    input  wire logic [16:0] strap_in,
    input  wire logic        boot_stop_in,
    output logic      [2:0]  src_sel_out,
    output logic      [16:0] strap_out,
    output logic             boot_stop_out,
    output logic             valid_out
);
    logic [2:0]  samp_sel;
    logic [16:0] samp_strap;
    logic        samp_stop;

    // keep sampling while power-on reset is held
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            samp_sel   <= rss_pkg::SRC_SEL_RESET;
            samp_strap <= rss_pkg::STRAP_RESET;
            samp_stop  <= 1'b0;
        end else if (capture_in) begin
            samp_sel   <= src_sel_in;
            samp_strap <= strap_in;
            samp_stop  <= boot_stop_in;
        end
    end

    // frozen at power-on release until the next power-on
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            src_sel_out   <= rss_pkg::SRC_SEL_RESET;
            strap_out     <= rss_pkg::STRAP_RESET;
            boot_stop_out <= 1'b0;
            valid_out     <= 1'b0;
        end else if (capture_in) begin
            valid_out <= 1'b0;
        end else if (commit_in) begin
            src_sel_out   <= samp_sel;
            strap_out     <= samp_strap;
            boot_stop_out <= (samp_sel == rss_pkg::CFG_SRC_I2C) ? samp_stop : 1'b0;
            valid_out     <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [rss_pkg.sv]
// shared constants and types for the reset source sequencer
package rss_pkg;
    localparam int unsigned POR_MIN_CYCLES   = 32;
    localparam int unsigned SRC_SEL_W        = 3;
    localparam int unsigned STRAP_W          = 17;
    localparam int unsigned STRETCH_CYCLES   = 16;
    localparam int unsigned CNT_W            = 6;
    localparam logic [2:0]  CFG_SRC_I2C      = 3'h0;
    localparam logic [2:0]  CFG_SRC_PINS     = 3'h1;
    localparam logic [2:0]  CFG_SRC_HARD     = 3'h2;
    localparam logic [1:0]  JCMD_EXTEST      = 2'h1;
    localparam logic [1:0]  JCMD_CLAMP       = 2'h2;
    localparam logic [1:0]  JCMD_HIGHZ      = 2'h3;
    localparam logic [16:0] STRAP_RESET      = 17'h00000;
    localparam logic [2:0]  SRC_SEL_RESET    = 3'h0;
    // one-hot source set: por, hard, soft, scan
    localparam int unsigned SRC_POR  = 0;
    localparam int unsigned SRC_HARD = 1;
    localparam int unsigned SRC_SOFT = 2;
    localparam int unsigned SRC_SCAN = 3;
    typedef enum logic [1:0] {
        RSS_IDLE,
        RSS_ASSERT,
        RSS_STRETCH
    } rss_state_e;
endpackage

// [rss_reset_source_sequencer.sv]
// reset source arbitration, domain reset fan-out and configuration capture
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        power_on_reset_in,
    input  wire logic        ext_hard_reset_in,
    input  wire logic        ext_soft_reset_in,
    input  wire logic        wdog_hard_req_in,
    input  wire logic        sw_hard_req_in,
    input  wire logic        link_hard_req_in,
    input  wire logic        sw_soft_req_in,
    input  wire logic        scan_cmd_valid_in,
    input  wire logic [1:0]  scan_cmd_in,
    input  wire logic        scan_clamp_soft_in,
    input  wire logic [2:0]  config_word_source_sel,
    input  wire logic [16:0] config_strap_pins,
    input  wire logic        boot_stop_strap,
    output logic             hard_reset_line_out,
    output logic             hard_reset_line_oe_out,
    output logic             soft_reset_line_out,
    output logic             soft_reset_line_oe_out,
    output logic             periph_bus_rst_out,
    output logic             ext_core_rst_out,
    output logic             icn_full_rst_out,
    output logic             icn_part_rst_out,
    output logic             timer_pmon_rst_out,
    output logic             comms_full_rst_out,
    output logic             comms_most_rst_out,
    output logic [1:0]       cfg_origin_out,
    output logic [2:0]       cfg_src_sel_out,
    output logic [16:0]      cfg_strap_out,
    output logic             cfg_boot_stop_out,
    output logic             cfg_valid_out,
    output logic [3:0]       last_source_out
);
    localparam logic [1:0] ORIGIN_I2C  = 2'h0;
    localparam logic [1:0] ORIGIN_PINS = 2'h1;
    localparam logic [1:0] ORIGIN_HARD = 2'h2;

    // pin inputs all cross into the clock domain first
    logic [6:0]  ctl_raw;
    logic [6:0]  ctl_s;
    logic [20:0] cfg_raw;
    logic [20:0] cfg_s;
    assign ctl_raw = {link_hard_req_in, sw_hard_req_in, wdog_hard_req_in, sw_soft_req_in,
                      ext_soft_reset_in, ext_hard_reset_in, power_on_reset_in};
    assign cfg_raw = {boot_stop_strap, config_word_source_sel, config_strap_pins};

    rss_sync #(.W(7)) u_ctl_sync (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .async_in   (ctl_raw),
        .rst_val_in (7'h00),
        .sync_out   (ctl_s)
    );

    rss_sync #(.W(21)) u_cfg_sync (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .async_in   (cfg_raw),
        .rst_val_in (21'h000000),
        .sync_out   (cfg_s)
    );

    logic por_s;
    logic hard_s;
    logic soft_s;
    logic scan_act;
    assign por_s  = ctl_s[0];
    assign hard_s = ctl_s[1] | ctl_s[4] | ctl_s[5] | ctl_s[6];
    assign soft_s = ctl_s[2] | ctl_s[3];
    // scan command comes from on-chip logic on this clock, no sync needed
    assign scan_act = scan_cmd_valid_in && (scan_cmd_in != 2'h0);

    function automatic logic scan_drives_soft(input logic [1:0] cmd, input logic clamp_soft);
        scan_drives_soft = (cmd == rss_pkg::JCMD_CLAMP) ? clamp_soft : (cmd != 2'h0);
    endfunction

    // highest active source, power-on first
    logic [3:0] next_src;
    always_comb begin
        next_src = 4'h0;
        if (por_s) begin
            next_src[rss_pkg::SRC_POR] = 1'b1;
        end else if (hard_s) begin
            next_src[rss_pkg::SRC_HARD] = 1'b1;
        end else if (soft_s) begin
            next_src[rss_pkg::SRC_SOFT] = 1'b1;
        end else if (scan_act) begin
            next_src[rss_pkg::SRC_SCAN] = 1'b1;
        end
    end

    rss_pkg::rss_state_e state;
    logic [3:0] src;
    logic [rss_pkg::CNT_W-1:0] cnt;
    logic scan_soft;
    logic por_prev;

    // a stronger source pre-empts a weaker one in RSS_ASSERT; in RSS_STRETCH only power-on or hard pre-empts
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state     <= rss_pkg::RSS_IDLE;
            src       <= 4'h0;
            cnt       <= '0;
            scan_soft <= 1'b0;
        end else begin
            unique case (state)
                rss_pkg::RSS_IDLE: begin
                    if (next_src != 4'h0) begin
                        state     <= rss_pkg::RSS_ASSERT;
                        src       <= next_src;
                        scan_soft <= scan_drives_soft(scan_cmd_in, scan_clamp_soft_in);
                    end
                end
                rss_pkg::RSS_ASSERT: begin
                    // lower one-hot code is the stronger source
                    if (next_src != 4'h0 && next_src < src) begin
                        src <= next_src;
                    end
                    if (next_src == 4'h0 || next_src > src) begin
                        state <= rss_pkg::RSS_STRETCH;
                        cnt   <= '0;
                    end
                end
                rss_pkg::RSS_STRETCH: begin
                    // short stretch so domains see a clean release
                    if (next_src != 4'h0 && (next_src[rss_pkg::SRC_POR] || next_src[rss_pkg::SRC_HARD])) begin
                        state <= rss_pkg::RSS_ASSERT;
                        src   <= next_src;
                    end else if (cnt == rss_pkg::CNT_W'(rss_pkg::STRETCH_CYCLES - 1)) begin
                        state <= rss_pkg::RSS_IDLE;
                        src   <= 4'h0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    logic act_por;
    logic act_hard;
    logic act_soft;
    logic act_scan;
    logic busy;
    assign busy     = (state != rss_pkg::RSS_IDLE);
    assign act_por  = busy && src[rss_pkg::SRC_POR];
    assign act_hard = busy && src[rss_pkg::SRC_HARD];
    assign act_soft = busy && src[rss_pkg::SRC_SOFT];
    assign act_scan = busy && src[rss_pkg::SRC_SCAN];

    logic full_class;
    logic any_class;
    assign full_class = act_por | act_hard;
    assign any_class  = full_class | act_soft | act_scan;

    // domain reset outputs, all registered
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            hard_reset_line_out    <= 1'b0;
            hard_reset_line_oe_out <= 1'b0;
            soft_reset_line_out    <= 1'b0;
            soft_reset_line_oe_out <= 1'b0;
            periph_bus_rst_out     <= 1'b0;
            ext_core_rst_out       <= 1'b0;
            icn_full_rst_out       <= 1'b0;
            icn_part_rst_out       <= 1'b0;
            timer_pmon_rst_out     <= 1'b0;
            comms_full_rst_out     <= 1'b0;
            comms_most_rst_out     <= 1'b0;
        end else begin
            hard_reset_line_oe_out <= full_class;
            soft_reset_line_oe_out <= full_class | act_soft | (act_scan & scan_soft);
            periph_bus_rst_out     <= any_class;
            ext_core_rst_out       <= any_class;
            icn_full_rst_out       <= full_class;
            icn_part_rst_out       <= any_class;
            timer_pmon_rst_out     <= full_class;
            comms_full_rst_out     <= full_class;
            comms_most_rst_out     <= any_class;
        end
    end

    // last sequence seen, and power-on history for the commit strobe
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            last_source_out <= 4'h0;
            por_prev        <= 1'b0;
        end else begin
            por_prev <= por_s;
            if (busy) begin
                last_source_out <= src;
            end
        end
    end

    logic cfg_capture;
    logic cfg_commit;
    assign cfg_capture = por_s;
    assign cfg_commit  = por_prev && !por_s;

    rss_cfg_latch u_cfg_latch (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .capture_in    (cfg_capture),
        .commit_in     (cfg_commit),
        .src_sel_in    (cfg_s[19:17]),
        .strap_in      (cfg_s[16:0]),
        .boot_stop_in  (cfg_s[20]),
        .src_sel_out   (cfg_src_sel_out),
        .strap_out     (cfg_strap_out),
        .boot_stop_out (cfg_boot_stop_out),
        .valid_out     (cfg_valid_out)
    );

    // decode while sampling so the origin matches the latched select,
    // not the pins one cycle after power-on has already ended
    logic [1:0] origin_stage;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            origin_stage   <= ORIGIN_HARD;
            cfg_origin_out <= ORIGIN_HARD;
        end else if (cfg_capture) begin
            unique case (cfg_s[19:17])
                rss_pkg::CFG_SRC_I2C:  origin_stage <= ORIGIN_I2C;
                rss_pkg::CFG_SRC_PINS: origin_stage <= ORIGIN_PINS;
                default:               origin_stage <= ORIGIN_HARD;
            endcase
        end else if (cfg_commit) begin
            cfg_origin_out <= origin_stage;
        end
    end

    // helper: cycles since power-on began
    logic [rss_pkg::CNT_W-1:0] por_len;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            por_len <= '0;
        end else if (por_s) begin
            por_len <= (por_len == '1) ? por_len : por_len + 1'b1;
        end else begin
            por_len <= '0;
        end
    end

    por_starts_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        $rose(por_s) |-> ##2 (hard_reset_line_oe_out && soft_reset_line_oe_out))
        else $error("power-on did not drive both lines");
    hard_line_class_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        hard_reset_line_oe_out |-> $past(act_por || act_hard))
        else $error("hard line driven for wrong source");
    soft_line_scan_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (act_scan && !full_class && !act_soft && !scan_soft) |=> !soft_reset_line_oe_out)
        else $error("soft line driven for non-driving scan command");
    periph_all_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        any_class |=> (periph_bus_rst_out && ext_core_rst_out))
        else $error("peripheral or core reset missed");
    core_scan_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        act_scan |=> ext_core_rst_out)
        else $error("scan did not reset cores");
    icn_subset_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        icn_full_rst_out |-> icn_part_rst_out)
        else $error("interconnect full reset without partial");
    timer_keep_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (busy && !full_class) |=> !timer_pmon_rst_out)
        else $error("timers reset by soft or scan");
    comms_most_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (act_soft && !full_class) |=> (comms_most_rst_out && !comms_full_rst_out))
        else $error("comms reset class wrong");
    cfg_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (cfg_valid_out && !por_s) |=> $stable(cfg_strap_out))
        else $error("strap latch changed outside power-on");
    cfg_commit_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        cfg_commit |=> (cfg_valid_out && cfg_src_sel_out == $past(cfg_s[19:17], 2)))
        else $error("configuration not committed");
    por_len_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (cfg_commit && por_len >= rss_pkg::CNT_W'(rss_pkg::POR_MIN_CYCLES)) |=> cfg_valid_out)
        else $error("long power-on did not commit");
    hard_preempt_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == rss_pkg::RSS_ASSERT && hard_s && !por_s && !src[rss_pkg::SRC_POR]) |=> src[rss_pkg::SRC_HARD])
        else $error("hard source did not pre-empt weaker one");
endmodule
`default_nettype wire

// [rss_sync.sv]
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rss_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // reset value is a constant per instance but unused; both stages reset to zero
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

    logic unused_rst;
    assign unused_rst = |rst_val_in;
endmodule
`default_nettype wire
